// ### verilog/fbw_flash_protect.sv
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fbw_flash_protect #(
	parameter logic FACTORY_LOCK = 1'b0
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	fbw_spi_if.dev           spi,
	input  wire logic        wp_n,
	input  wire logic        power_up,
	input  wire logic        status_write_disable_bit,
	input  wire logic [3:0]  range_protect_bits,
	input  wire logic        continuous_program_mode,
	input  wire logic        engine_prog_fail,
	input  wire logic        engine_erase_fail,
	output logic             range_bits_writable,
	output logic [7:0]       security_protection_register,
	output logic             write_go,
	output logic             write_erase,
	output logic [23:0]      write_addr
);
	localparam int nb = fbw_pkg::num_blocks;

	typedef struct packed {
		logic          cs_m;
		logic          cs_y;
		logic          cs_q;
		logic          sck_m;
		logic          sck_y;
		logic          sck_q;
		logic          mo_m;
		logic          mo_y;
		logic          wp_m;
		logic          wp_y;
		logic [5:0]    bits;
		logic [31:0]   sh;
		logic [7:0]    op;
		logic [7:0]    out;
		logic          oe;
		logic          miso;
		logic          wel;
		logic          otp;
		logic          block_mode_select;
		logic          otp_lockdown_bit;
		logic          efail;
		logic          pfail;
		logic [nb-1:0] locks;
		logic          go;
		logic          erase;
		logic [23:0]   addr;
	} fbw_dev_state_type;

	localparam fbw_dev_state_type rst_state = '{
		cs_m: 1'b1, cs_y: 1'b1, cs_q: 1'b1, wp_m: 1'b1, wp_y: 1'b1,
		locks: {nb{1'b1}}, default: '0};

	fbw_dev_state_type s;
	fbw_dev_state_type n;
	logic [31:0]       w;

	// ----------------------------------------------------------------
	// Protection decision for one 64 KB block.
	// ----------------------------------------------------------------
	function automatic logic prot(input logic m, input logic wp, input logic [nb-1:0] lk,
		input logic [3:0] bp, input logic [7:0] blk);
		int span;
		span = (bp == 4'h0) ? 0 : (1 << (int'(bp) - 1));
		if (m) begin
			return !wp || lk[blk];
		end
		return (int'(blk) + span) >= nb;
	endfunction

	assign w = {s.sh[30:0], s.mo_y};
	assign spi.miso = s.miso;
	assign spi.miso_oe = s.oe;
	assign range_bits_writable = s.block_mode_select || !(status_write_disable_bit && !s.wp_y);
	assign security_protection_register = {s.block_mode_select, s.efail, s.pfail,
		continuous_program_mode, 2'b00, s.otp_lockdown_bit, FACTORY_LOCK};
	assign write_go = s.go;
	assign write_erase = s.erase;
	assign write_addr = s.addr;

	// ----------------------------------------------------------------
	// Serial front end and command execution.
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		n.cs_m = spi.cs_n;
		n.cs_y = s.cs_m;
		n.cs_q = s.cs_y;
		n.sck_m = spi.sclk;
		n.sck_y = s.sck_m;
		n.sck_q = s.sck_y;
		n.mo_m = spi.mosi;
		n.mo_y = s.mo_m;
		n.wp_m = wp_n;
		n.wp_y = s.wp_m;
		n.go = 1'b0;
		if (s.cs_q && !s.cs_y) begin
			n.bits = '0;
			n.oe = 1'b0;
		end else if (!s.cs_y && !s.sck_q && s.sck_y) begin
			n.sh = w;
			if (s.bits != fbw_pkg::bits_limit) begin
				n.bits = s.bits + 6'h01;
			end
			if (s.bits == fbw_pkg::bits_opcode - 6'h01) begin
				n.op = w[7:0];
				if (w[7:0] == fbw_pkg::security_reg_read_cmd) begin
					n.out = security_protection_register;
					n.oe = 1'b1;
				end
			end
			if (s.bits == fbw_pkg::bits_address - 6'h01) begin
				n.addr = w[23:0];
				if (s.op == fbw_pkg::read_lock_status_cmd && s.block_mode_select) begin
					n.out = {7'h00, prot(1'b1, s.wp_y, s.locks, range_protect_bits,
						w[fbw_pkg::block_msb:fbw_pkg::block_lsb])};
					n.oe = 1'b1;
				end
			end
		end else if (!s.cs_y && s.sck_q && !s.sck_y && s.oe) begin
			n.miso = s.out[7];
			n.out = {s.out[6:0], s.out[7]};
		end else if (!s.cs_q && s.cs_y) begin
			n.oe = 1'b0;
			case (s.op)
				fbw_pkg::write_enable_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode) begin
						n.wel = 1'b1;
					end
				end
				fbw_pkg::write_disable_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode) begin
						n.wel = 1'b0;
					end
				end
				fbw_pkg::security_reg_write_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode && !s.otp) begin
						n.otp_lockdown_bit = 1'b1;
					end
				end
				fbw_pkg::mode_select_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode && !s.otp) begin
						n.block_mode_select = 1'b1;
					end
				end
				fbw_pkg::single_block_lock_cmd, fbw_pkg::single_block_unlock_cmd: begin
					if (s.bits == fbw_pkg::bits_address && s.block_mode_select && s.wel
						&& !s.otp) begin
						n.locks[s.addr[fbw_pkg::block_msb:fbw_pkg::block_lsb]] =
							(s.op == fbw_pkg::single_block_lock_cmd);
						n.wel = 1'b0;
					end
				end
				fbw_pkg::chip_lock_all_cmd, fbw_pkg::chip_unlock_all_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode && s.block_mode_select && s.wel
						&& !s.otp) begin
						n.locks = {nb{s.op == fbw_pkg::chip_lock_all_cmd}};
						n.wel = 1'b0;
					end
				end
				fbw_pkg::fail_flag_clear_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode) begin
						n.efail = 1'b0;
						n.pfail = 1'b0;
					end
				end
				fbw_pkg::page_program_cmd: begin
					if (s.bits >= fbw_pkg::bits_prog_min && s.bits[2:0] == 3'h0 && s.wel) begin
						n.wel = 1'b0;
						if (s.otp ? s.otp_lockdown_bit : prot(s.block_mode_select, s.wp_y,
							s.locks, range_protect_bits,
							s.addr[fbw_pkg::block_msb:fbw_pkg::block_lsb])) begin
							n.pfail = 1'b1;
						end else begin
							n.go = 1'b1;
							n.erase = 1'b0;
						end
					end
				end
				fbw_pkg::sector_erase_cmd, fbw_pkg::block_erase_cmd: begin
					if (s.bits == fbw_pkg::bits_address && s.wel) begin
						n.wel = 1'b0;
						if (s.otp ? s.otp_lockdown_bit : prot(s.block_mode_select, s.wp_y,
							s.locks, range_protect_bits,
							s.addr[fbw_pkg::block_msb:fbw_pkg::block_lsb])) begin
							n.efail = 1'b1;
						end else begin
							n.go = 1'b1;
							n.erase = 1'b1;
						end
					end
				end
				fbw_pkg::otp_enter_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode) begin
						n.otp = 1'b1;
					end
				end
				fbw_pkg::otp_exit_cmd: begin
					if (s.bits == fbw_pkg::bits_opcode) begin
						n.otp = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (engine_prog_fail) begin
			n.pfail = 1'b1;
		end
		if (engine_erase_fail) begin
			n.efail = 1'b1;
		end
		if (power_up) begin
			n.locks = {nb{1'b1}};
			n.wel = 1'b0;
			n.otp = 1'b0;
			n.efail = 1'b0;
			n.pfail = 1'b0;
			n.oe = 1'b0;
			n.go = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= rst_state;
		end else begin
			s <= n;
		end
	end
endmodule
`default_nettype wire

// ### verilog/fbw_pkg.sv
package fbw_pkg;
	// ----------------------------------------------------------------
	// Command codes.
	// ----------------------------------------------------------------
	localparam logic [7:0] write_enable_cmd        = 8'h06;
	localparam logic [7:0] write_disable_cmd       = 8'h04;
	localparam logic [7:0] security_reg_write_cmd  = 8'h2f;
	localparam logic [7:0] security_reg_read_cmd   = 8'h2b;
	localparam logic [7:0] mode_select_cmd         = 8'h68;
	localparam logic [7:0] single_block_lock_cmd   = 8'h36;
	localparam logic [7:0] single_block_unlock_cmd = 8'h39;
	localparam logic [7:0] read_lock_status_cmd    = 8'h3c;
	localparam logic [7:0] chip_lock_all_cmd       = 8'h7e;
	localparam logic [7:0] chip_unlock_all_cmd     = 8'h98;
	localparam logic [7:0] fail_flag_clear_cmd     = 8'h30;
	localparam logic [7:0] page_program_cmd        = 8'h02;
	localparam logic [7:0] sector_erase_cmd        = 8'h20;
	localparam logic [7:0] block_erase_cmd         = 8'hd8;
	localparam logic [7:0] otp_enter_cmd           = 8'hb1;
	localparam logic [7:0] otp_exit_cmd            = 8'hc1;
	// ----------------------------------------------------------------
	// Frame lengths in bits.
	// ----------------------------------------------------------------
	localparam logic [5:0] bits_opcode   = 6'h08;
	localparam logic [5:0] bits_address  = 6'h20;
	localparam logic [5:0] bits_prog_min = 6'h28;
	localparam logic [5:0] bits_limit    = 6'h30;
	// ----------------------------------------------------------------
	// Array geometry.
	// ----------------------------------------------------------------
	localparam int num_blocks = 256;
	localparam int block_msb  = 23;
	localparam int block_lsb  = 16;
	// ----------------------------------------------------------------
	// Controller register map and fields.
	// ----------------------------------------------------------------
	localparam logic [7:0] reg_ctrl        = 8'h00;
	localparam logic [7:0] reg_addr        = 8'h04;
	localparam logic [7:0] reg_status      = 8'h08;
	localparam int         ctrl_nread_lsb  = 10;
	localparam int         ctrl_extra_lsb  = 13;
	localparam int         ctrl_start_bit  = 16;
	localparam logic [1:0] resp_okay       = 2'h0;
	localparam logic [1:0] resp_slverr     = 2'h2;
	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int clk_period_ns     = 4;
	localparam int sclk_period_ns    = 64;
	localparam int sclk_half_cycles  = sclk_period_ns / (2 * clk_period_ns);
	localparam int end_gap_cycles    = 4;
endpackage

// ### verilog/fbw_spi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fbw_spi_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic miso_oe;
	modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe);
	modport host (output cs_n, output sclk, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

// ### verilog/fbw_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module fbw_spi_host #(
	parameter int SCLK_HALF = fbw_pkg::sclk_half_cycles
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	fbw_spi_if.host          spi
);
	typedef enum {st_idle, st_run, st_gap} fbw_host_phase_type;

	typedef struct packed {
		logic               aw_have;
		logic [7:0]         aw_addr;
		logic               w_have;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
		logic [31:0]        ctrl;
		logic [31:0]        addr;
		fbw_host_phase_type phase;
		logic [7:0]         div;
		logic [7:0]         cnt;
		logic [7:0]         total;
		logic [31:0]        tx;
		logic [7:0]         rx;
		logic               cs_n;
		logic               sclk;
		logic               mi_m;
		logic               mi_y;
	} fbw_host_state_type;

	localparam fbw_host_state_type rst_state = '{cs_n: 1'b1, phase: st_idle, default: '0};

	fbw_host_state_type s;
	fbw_host_state_type n;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	assign s_axi_awready = !s.aw_have && !s.bvalid;
	assign s_axi_wready = !s.w_have && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign spi.cs_n = s.cs_n;
	assign spi.sclk = s.sclk;
	assign spi.mosi = s.tx[31];

	// ----------------------------------------------------------------
	// Register slave and serial engine.
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		n.mi_m = spi.miso;
		n.mi_y = s.mi_m;
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_have = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_have = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_have && s.w_have) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = fbw_pkg::resp_okay;
			case (s.aw_addr)
				fbw_pkg::reg_ctrl: begin
					n.ctrl = merge(s.ctrl, s.w_data, s.w_strb);
				end
				fbw_pkg::reg_addr: begin
					n.addr = merge(s.addr, s.w_data, s.w_strb);
				end
				fbw_pkg::reg_status: begin
				end
				default: begin
					n.bresp = fbw_pkg::resp_slverr;
				end
			endcase
		end
		if (s_axi_arvalid && !s.rvalid) begin
			n.rvalid = 1'b1;
			n.rresp = fbw_pkg::resp_okay;
			case (s_axi_araddr)
				fbw_pkg::reg_ctrl: n.rdata = s.ctrl;
				fbw_pkg::reg_addr: n.rdata = s.addr;
				fbw_pkg::reg_status: n.rdata = {16'h0000, s.rx, 7'h00, s.phase != st_idle};
				default: begin
					n.rdata = '0;
					n.rresp = fbw_pkg::resp_slverr;
				end
			endcase
		end else if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		case (s.phase)
			st_idle: begin
				if (s.ctrl[fbw_pkg::ctrl_start_bit]) begin
					n.ctrl[fbw_pkg::ctrl_start_bit] = 1'b0;
					n.phase = st_run;
					n.cs_n = 1'b0;
					n.div = '0;
					n.cnt = '0;
					n.tx = {s.ctrl[7:0], s.addr[23:0]};
					n.total = {2'b00, 3'h0, 3'h1} * 8'h08 + {6'h00, s.ctrl[9:8]} * 8'h08
						+ {5'h00, s.ctrl[fbw_pkg::ctrl_nread_lsb +: 3]} * 8'h08
						+ {5'h00, s.ctrl[fbw_pkg::ctrl_extra_lsb +: 3]};
				end
			end
			st_run: begin
				n.div = s.div + 8'h01;
				if (s.div == 8'(SCLK_HALF - 1)) begin
					n.div = '0;
					if (s.cnt == s.total) begin
						n.cs_n = 1'b1;
						n.sclk = 1'b0;
						n.phase = st_gap;
					end else if (!s.sclk) begin
						n.sclk = 1'b1;
						n.rx = {s.rx[6:0], s.mi_y};
						n.cnt = s.cnt + 8'h01;
					end else begin
						n.sclk = 1'b0;
						n.tx = {s.tx[30:0], 1'b0};
					end
				end
			end
			st_gap: begin
				n.div = s.div + 8'h01;
				if (s.div == 8'(fbw_pkg::end_gap_cycles - 1)) begin
					n.phase = st_idle;
				end
			end
			default: n.phase = st_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= rst_state;
		end else begin
			s <= n;
		end
	end
endmodule
`default_nettype wire

// ### bench/fbw_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fbw_link_assertions #(
	parameter int SCLK_HALF = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	// ----------------------------------------------------------------
	// Frame bookkeeping: rises per frame and length of each clock level.
	// ----------------------------------------------------------------
	logic       sclk_q;
	logic [5:0] nrise;
	logic [9:0] run;
	always_ff @(posedge aclk) begin
		sclk_q <= sclk;
		if (sclk != sclk_q) begin
			run <= 10'h001;
		end else if (run != 10'h3ff) begin
			run <= run + 10'h001;
		end
		if (!aresetn || cs_n) begin
			nrise <= 6'h00;
		end else if (sclk && !sclk_q && nrise != 6'h3f) begin
			nrise <= nrise + 6'h01;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_idle_clock_low: assert property (cs_n && $past(cs_n) |-> !sclk)
		else $error("serial clock moves outside a frame");
	a_high_half: assert property ($fell(sclk) && !cs_n |-> run == 10'(SCLK_HALF))
		else $error("serial clock high phase has the wrong length");
	a_low_half: assert property ($rose(sclk) && nrise != 6'h00 |-> run == 10'(SCLK_HALF))
		else $error("serial clock low phase has the wrong length");
	a_select_setup: assert property ($fell(cs_n) |-> (!sclk)[*4])
		else $error("serial clock rises too soon after select");
	a_data_held: assert property (!cs_n && sclk && $past(sclk) |-> $stable(mosi))
		else $error("host data moves while the clock is high");
	a_reply_held: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso))
		else $error("device data moves while the clock is high");
	a_quiet_opcode: assert property (miso_oe && !cs_n |-> nrise >= 6'h08)
		else $error("device drives data during the opcode");
	a_release_oe: assert property ($rose(cs_n) |-> ##[1:5] !miso_oe)
		else $error("device keeps driving after deselect");
	cover property ($rose(miso_oe));
	cover property ($rose(cs_n) && nrise == 6'h20);
	cover property ($rose(cs_n) && nrise[2:0] != 3'h0);
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, wp_n, power_up, swd, cp, pfail, efail;
	logic        rbw, go, go_erase, go_seen, seen_erase;
	logic [1:0]  bresp, rresp, resp;
	logic [3:0]  bp;
	logic [7:0]  awaddr, araddr, sec, rx;
	logic [23:0] go_addr, seen_addr;
	logic [31:0] wdata, rdata, rd;
	int          fails = 0;
	int          tests_run = 0;
	fbw_spi_if spi_bus ();
	fbw_flash_protect #(.FACTORY_LOCK(1'b1)) u_fbw_flash_protect (
		.aclk(aclk), .aresetn(aresetn), .spi(spi_bus), .wp_n(wp_n), .power_up(power_up),
		.status_write_disable_bit(swd), .range_protect_bits(bp), .continuous_program_mode(cp),
		.engine_prog_fail(pfail), .engine_erase_fail(efail), .range_bits_writable(rbw),
		.security_protection_register(sec), .write_go(go), .write_erase(go_erase),
		.write_addr(go_addr));
	fbw_spi_host #(.SCLK_HALF(8)) u_fbw_spi_host (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .spi(spi_bus));
	fbw_link_assertions #(.SCLK_HALF(8)) u_fbw_link_assertions (
		.aclk(aclk), .aresetn(aresetn), .cs_n(spi_bus.cs_n), .sclk(spi_bus.sclk),
		.mosi(spi_bus.mosi), .miso(spi_bus.miso), .miso_oe(spi_bus.miso_oe));
	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (go === 1'b1) begin
			go_seen = 1'b1;
			seen_addr = go_addr;
			seen_erase = go_erase;
		end
	end
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic frame(input logic [7:0] op, input logic [1:0] nab, input logic [2:0] nrd,
		input logic [2:0] ex, input logic [23:0] a);
		go_seen = 1'b0;
		axi_wr(fbw_pkg::reg_addr, {8'h00, a});
		axi_wr(fbw_pkg::reg_ctrl, {15'h0000, 1'b1, ex, nrd, nab, op});
		while (spi_bus.cs_n !== 1'b0) @(posedge aclk);
		while (spi_bus.cs_n !== 1'b1) @(posedge aclk);
		repeat (8) @(posedge aclk);
		do axi_rd(fbw_pkg::reg_status); while (rd[0] !== 1'b0);
		rx = rd[15:8];
	endtask
	task automatic wf(input logic [7:0] op, input logic [1:0] nab, input logic [2:0] nrd,
		input logic [2:0] ex, input logic [23:0] a);
		frame(8'h06, 2'h0, 3'h0, 3'h0, 24'h0);
		frame(op, nab, nrd, ex, a);
	endtask
	task automatic lk(input logic [23:0] a, input logic [7:0] exp);
		frame(8'h3c, 2'h3, 3'h1, 3'h0, a);
		chk_byte(rx, exp);
	endtask
	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_flags;
		chk_byte(sec, 8'h01);
		axi_rd(8'h0c);
		chk_byte({6'h00, resp}, {6'h00, fbw_pkg::resp_slverr});
		axi_wr(8'h0c, 32'h0000_0001);
		chk_byte({6'h00, resp}, {6'h00, fbw_pkg::resp_slverr});
		frame(8'h2b, 2'h0, 3'h1, 3'h0, 24'h0);
		chk_byte(rx, 8'h01);
		cp <= 1'b1;
		pfail <= 1'b1;
		efail <= 1'b1;
		@(posedge aclk);
		pfail <= 1'b0;
		efail <= 1'b0;
		repeat (2) @(posedge aclk);
		chk_byte(sec, 8'h71);
		frame(8'h30, 2'h0, 3'h0, 3'h1, 24'h0);
		chk_byte(sec, 8'h71);
		frame(8'h30, 2'h0, 3'h0, 3'h0, 24'h0);
		chk_byte(sec, 8'h11);
		cp <= 1'b0;
	endtask
	task automatic t_range;
		for (int i = 0; i < 4; i++) begin
			swd <= i[0];
			wp_n <= i[1];
			repeat (4) @(posedge aclk);
			chk_flag(rbw, !(i[0] && !i[1]));
		end
		bp <= 4'h1;
		wf(8'h39, 2'h3, 3'h0, 3'h0, 24'h030000);
		wf(8'h02, 2'h3, 3'h1, 3'h0, 24'hff0000);
		chk_flag(go_seen, 1'b0);
		chk_byte(sec, 8'h21);
		wf(8'h20, 2'h3, 3'h0, 3'h0, 24'hff1000);
		chk_flag(go_seen, 1'b0);
		chk_byte(sec, 8'h61);
		wf(8'h02, 2'h3, 3'h1, 3'h0, 24'h000000);
		chk_flag(go_seen, 1'b1);
		frame(8'h30, 2'h0, 3'h0, 3'h0, 24'h0);
	endtask
	task automatic t_otp;
		frame(8'h2f, 2'h0, 3'h0, 3'h3, 24'h0);
		chk_byte(sec, 8'h01);
		frame(8'h2f, 2'h0, 3'h0, 3'h0, 24'h0);
		chk_byte(sec, 8'h03);
		frame(8'hb1, 2'h0, 3'h0, 3'h0, 24'h0);
		wf(8'h02, 2'h3, 3'h1, 3'h0, 24'h0);
		chk_flag(go_seen, 1'b0);
		chk_byte(sec, 8'h23);
		frame(8'hc1, 2'h0, 3'h0, 3'h0, 24'h0);
		frame(8'h30, 2'h0, 3'h0, 3'h0, 24'h0);
	endtask
	task automatic t_blocks;
		frame(8'h68, 2'h0, 3'h0, 3'h1, 24'h0);
		chk_byte(sec, 8'h03);
		frame(8'h68, 2'h0, 3'h0, 3'h0, 24'h0);
		chk_byte(sec, 8'h83);
		lk(24'h030000, 8'h01);
		wf(8'h02, 2'h3, 3'h1, 3'h0, 24'h000000);
		chk_flag(go_seen, 1'b0);
		chk_byte(sec, 8'ha3);
		frame(8'h30, 2'h0, 3'h0, 3'h0, 24'h0);
		wf(8'h39, 2'h3, 3'h0, 3'h0, 24'h000000);
		lk(24'h000000, 8'h00);
		wf(8'h02, 2'h3, 3'h1, 3'h0, 24'h000100);
		chk_flag(go_seen, 1'b1);
		chk_byte(seen_addr[15:8], 8'h01);
		chk_flag(seen_erase, 1'b0);
		wp_n <= 1'b0;
		lk(24'h000000, 8'h01);
		chk_flag(rbw, 1'b1);
		wf(8'h02, 2'h3, 3'h1, 3'h0, 24'h000000);
		chk_flag(go_seen, 1'b0);
		wp_n <= 1'b1;
		frame(8'h30, 2'h0, 3'h0, 3'h0, 24'h0);
		wf(8'h36, 2'h3, 3'h0, 3'h0, 24'h000000);
		lk(24'h000000, 8'h01);
		wf(8'h39, 2'h3, 3'h0, 3'h4, 24'h000000);
		lk(24'h000000, 8'h01);
		wf(8'h98, 2'h0, 3'h0, 3'h0, 24'h0);
		lk(24'h05f000, 8'h00);
		wf(8'hd8, 2'h3, 3'h0, 3'h0, 24'h050000);
		chk_flag(go_seen, 1'b1);
		chk_flag(seen_erase, 1'b1);
		chk_byte(seen_addr[23:16], 8'h05);
		wf(8'h02, 2'h3, 3'h1, 3'h0, 24'hff0000);
		chk_flag(go_seen, 1'b1);
		wf(8'h7e, 2'h0, 3'h0, 3'h0, 24'h0);
		lk(24'h05f000, 8'h01);
		wf(8'h98, 2'h0, 3'h0, 3'h0, 24'h0);
		power_up <= 1'b1;
		@(posedge aclk);
		power_up <= 1'b0;
		lk(24'h000000, 8'h01);
		chk_byte(sec, 8'h83);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		chk_byte(sec, 8'h01);
	endtask
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		#300000;
		fails++;
		finish_test();
	end
	initial begin
		aresetn = 1'b0;
		wp_n = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, power_up, swd, cp, pfail, efail} = '0;
		{awaddr, araddr, bp} = '0;
		wdata = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_flags();
		t_range();
		t_otp();
		t_blocks();
		finish_test();
	end
endmodule
`default_nettype wire
